/* atx_fan_model.sv */
// ATX supply with standby rail and a four-wire fan.
// Assumes the bench drives cut to take the standby rail away.
`timescale 1ns/100ps
`default_nettype none
module atx_fan_model #(parameter int PULSE_CYCLES = 10) (
  // Clock and mains command
  input  wire logic ref_clk,
  input  wire logic cut,
  input  wire logic supply_on_request_n,
  // Rail and tach
  output var logic  standby_present,
  output var logic  fan_rotation_pulse_in = 1'b1
);
  int cnt_q = 0;
  // Standby stays up unless mains is cut
  assign standby_present = !cut;
  // Fan turns only with main outputs on; tach line pulled up when still
  always @(posedge ref_clk) begin
    cnt_q <= (supply_on_request_n || cnt_q == PULSE_CYCLES - 1) ? 0 : cnt_q + 1;
    fan_rotation_pulse_in <= supply_on_request_n || cnt_q < PULSE_CYCLES / 2;
  end
endmodule // atx_fan_model
`default_nettype wire

/* power_loss_and_fan_supervisor.v */
// Power loss supervision, restore policy, enhanced soft-off wake and fan
// control with tachometer readout, behind a simple register port.
// Assumes all inputs synchronous to ref_clk and a standby-powered clock.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_consts.vh"

module power_loss_and_fan_supervisor #(
  parameter [30:0] WINDOW_CYCLES = `WINDOW_CYCLES_DEF,
  parameter [30:0] GATE_CYCLES   = `GATE_CYCLES_DEF
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [15:0] reg_rdata,
  // Supply side
  input  wire        standby_present,
  input  wire        standby_rail_fitted,
  output wire        supply_on_request_n,
  // Wake sources
  input  wire        power_button_n,
  input  wire        sleep_button_n,
  input  wire        smbalert_n,
  // Fan
  output wire        fan_speed_drive,
  input  wire        fan_rotation_pulse_in,
  // Interrupt
  output wire        irq
);

  localparam [2:0] ST_OFF   = 3'h0;
  localparam [2:0] ST_ON    = 3'h1;
  localparam [2:0] ST_WATCH = 3'h2;
  localparam [2:0] ST_ESO   = 3'h3;
  localparam [2:0] ST_LOST  = 3'h4;

  localparam [31:0] TACH_SCALE_FULL =
    `SEC_PER_MIN / (`TACH_GATE_SEC * `TACH_PULSES_PER_REV);
  localparam [15:0] TACH_SCALE      = TACH_SCALE_FULL[15:0];

  reg  [2:0]            state_q;
  reg  [2:0]            state_d;
  reg                   last_on_q;
  reg                   last_on_d;
  reg  [1:0]            policy_q;
  reg  [1:0]            policy_d;
  reg  [1:0]            class_q;
  reg  [1:0]            class_d;
  reg  [30:0]           win_cnt_q;
  reg  [30:0]           win_cnt_d;
  reg  [`IRQ_WIDTH-1:0] events;
  reg                   stby_q;
  reg                   pwr_btn_q;
  reg                   slp_btn_q;
  reg                   alert_q;
  reg                   supply_n_q;
  reg                   on_cmd;
  reg                   off_cmd;
  reg                   eso_cmd;
  reg  [7:0]            duty_q;
  reg  [7:0]            pwm_cnt_q;
  reg                   pwm_q;
  reg                   tach_q;
  reg  [10:0]           pulse_cnt_q;
  reg  [30:0]           gate_cnt_q;
  reg  [15:0]           rpm_q;
  reg  [`IRQ_WIDTH-1:0] mask_q;
  reg  [15:0]           rdata_q;
  wire [`IRQ_WIDTH-1:0] irq_stat_q;
  wire [7:0]            store_rd;
  wire                  pwr_press;
  wire                  slp_press;
  wire                  alert_fall;
  wire                  wake_any;
  wire                  tach_rise;
  wire                  stat_clr;
  wire [15:0]           rpm_calc;

  // Input history for edge detection, standby sampled without pause
  always @(posedge ref_clk) begin
    if (reset) begin
      stby_q    <= 1'b1; // Rail assumed up, so reset alone is no loss
      pwr_btn_q <= 1'b1;
      slp_btn_q <= 1'b1;
      alert_q   <= 1'b1;
      tach_q    <= 1'b1; // Idle tach level, no false edge after reset
    end else begin
      stby_q    <= standby_present;
      pwr_btn_q <= power_button_n;
      slp_btn_q <= sleep_button_n;
      alert_q   <= smbalert_n;
      tach_q    <= fan_rotation_pulse_in;
    end
  end

  assign pwr_press  = pwr_btn_q & ~power_button_n;
  assign slp_press  = slp_btn_q & ~sleep_button_n;
  assign alert_fall = alert_q & ~smbalert_n;
  assign wake_any   = pwr_press | slp_press | alert_fall;
  assign tach_rise  = ~tach_q & fan_rotation_pulse_in;

  // Software command pulses from a control write
  always @* begin
    on_cmd  = 1'b0;
    off_cmd = 1'b0;
    eso_cmd = 1'b0;
    if (reg_wr && (reg_addr == `ADDR_CONTROL)) begin
      on_cmd  = reg_wdata[`CTL_ON_CMD];
      off_cmd = reg_wdata[`CTL_OFF_CMD];
      eso_cmd = reg_wdata[`CTL_ESO_CMD];
    end
  end

  // Power state machine
  always @* begin
    state_d   = state_q;
    last_on_d = last_on_q;
    policy_d  = policy_q;
    class_d   = class_q;
    win_cnt_d = win_cnt_q;
    events    = {`IRQ_WIDTH{1'b0}};
    if (reg_wr && (reg_addr == `ADDR_CONTROL)) begin
      policy_d = reg_wdata[`CTL_POLICY_MSB:`CTL_POLICY_LSB];
    end
    case (state_q)
      ST_OFF: begin
        if (!stby_q) begin
          state_d = ST_LOST;
          class_d = `CLASS_AC_LOSS;
          events[`EV_AC_LOSS] = 1'b1;
        end else if (pwr_press || on_cmd) begin
          state_d   = ST_ON;
          last_on_d = 1'b1;
          events[`EV_POWER_ON] = 1'b1;
        end else if (eso_cmd) begin
          state_d = ST_ESO;
        end
      end
      ST_ON: begin
        if (!stby_q) begin
          state_d = ST_LOST;
          class_d = `CLASS_AC_LOSS;
          events[`EV_AC_LOSS] = 1'b1;
        end else if (pwr_press || off_cmd) begin
          events[`EV_POWER_OFF] = 1'b1;
          if (standby_rail_fitted && (policy_q == `POLICY_LAST)) begin
            // Last state stays on until the window proves an orderly off
            state_d   = ST_WATCH;
            win_cnt_d = 31'h00000000;
            class_d   = `CLASS_NONE;
          end else begin
            state_d   = ST_OFF;
            last_on_d = 1'b0;
          end
        end
      end
      ST_WATCH: begin
        if (!stby_q) begin
          state_d = ST_LOST;
          class_d = `CLASS_AC_LOSS;
          events[`EV_AC_LOSS] = 1'b1;
        end else if (win_cnt_q >= WINDOW_CYCLES - 31'h00000001) begin
          state_d   = ST_OFF;
          class_d   = `CLASS_ORDERLY;
          last_on_d = 1'b0;
          events[`EV_ORDERLY] = 1'b1;
        end else begin
          win_cnt_d = win_cnt_q + 31'h00000001;
        end
      end
      ST_ESO: begin
        if (!stby_q) begin
          state_d = ST_LOST;
          class_d = `CLASS_AC_LOSS;
          events[`EV_AC_LOSS] = 1'b1;
        end else if (wake_any) begin
          state_d   = ST_ON;
          last_on_d = 1'b1;
          events[`EV_WAKE]     = 1'b1;
          events[`EV_POWER_ON] = 1'b1;
        end
      end
      ST_LOST: begin
        if (stby_q) begin
          // Working copies come back from the retained store
          policy_d  = store_rd[`STORE_POL_MSB:`STORE_POL_LSB];
          last_on_d = store_rd[`STORE_LAST_BIT];
          if (!standby_rail_fitted) begin
            state_d = ST_ON;
          end else if (policy_d == `POLICY_ON) begin
            state_d = ST_ON;
          end else if (policy_d == `POLICY_OFF) begin
            state_d = ST_OFF;
          end else if (store_rd[`STORE_LAST_BIT]) begin
            state_d = ST_ON;
          end else begin
            state_d = ST_OFF;
          end
          if (state_d == ST_ON) begin
            last_on_d = 1'b1;
            events[`EV_POWER_ON] = 1'b1;
          end
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // State registers and supply request
  always @(posedge ref_clk) begin
    if (reset) begin
      state_q    <= ST_OFF;
      last_on_q  <= 1'b0;
      policy_q   <= `POLICY_RESET;
      class_q    <= `CLASS_NONE;
      win_cnt_q  <= 31'h00000000;
      supply_n_q <= 1'b1;
    end else begin
      state_q    <= state_d;
      last_on_q  <= last_on_d;
      policy_q   <= policy_d;
      class_q    <= class_d;
      win_cnt_q  <= win_cnt_d;
      supply_n_q <= (state_d != ST_ON);
    end
  end

  assign supply_on_request_n = supply_n_q;

  // Retained copy of policy and last state, frozen while power is lost
  retain_store u_store (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (state_q != ST_LOST),
    .wr_idx  (`STORE_IDX),
    .wr_data ({5'h00, policy_q, last_on_q}),
    .rd_idx  (`STORE_IDX),
    .rd_data (store_rd)
  );

  // Fan PWM: free running counter compared with the duty
  always @(posedge ref_clk) begin
    if (reset) begin
      duty_q    <= `DUTY_RESET;
      pwm_cnt_q <= 8'h00;
      pwm_q     <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == `ADDR_FAN_DUTY)) begin
        duty_q <= reg_wdata[7:0];
      end
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      pwm_q     <= (pwm_cnt_q < duty_q);
    end
  end

  assign fan_speed_drive = pwm_q;

  // Tach edges over a gate, scaled to a minute per two pulses a turn
  assign rpm_calc = {5'h00, pulse_cnt_q} * TACH_SCALE;

  always @(posedge ref_clk) begin
    if (reset) begin
      pulse_cnt_q <= 11'h000;
      gate_cnt_q  <= 31'h00000000;
      rpm_q       <= 16'h0000;
    end else if (gate_cnt_q >= GATE_CYCLES - 31'h00000001) begin
      gate_cnt_q  <= 31'h00000000;
      rpm_q       <= rpm_calc;
      pulse_cnt_q <= {10'h000, tach_rise};
    end else begin
      gate_cnt_q <= gate_cnt_q + 31'h00000001;
      if (tach_rise && (pulse_cnt_q != 11'h7FF)) begin
        pulse_cnt_q <= pulse_cnt_q + 11'h001; // Saturates
      end
    end
  end

  // Sticky status bits, read clears, a new event wins over the clear
  assign stat_clr = reg_rd && (reg_addr == `ADDR_IRQ_STATUS);

  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1) begin : g_stat
      reg bit_q;
      always @(posedge ref_clk) begin
        if (reset) begin
          bit_q <= 1'b0;
        end else if (events[gi]) begin
          bit_q <= 1'b1;
        end else if (stat_clr) begin
          bit_q <= 1'b0;
        end
      end
      assign irq_stat_q[gi] = bit_q;
    end
  endgenerate

  // Interrupt mask
  always @(posedge ref_clk) begin
    if (reset) begin
      mask_q <= `MASK_RESET;
    end else if (reg_wr && (reg_addr == `ADDR_IRQ_MASK)) begin
      mask_q <= reg_wdata[`IRQ_WIDTH-1:0];
    end
  end

  assign irq = |(irq_stat_q & mask_q);

  // Read data, valid only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `ADDR_CONTROL) begin
        rdata_q <= {14'h0000, policy_q};
      end else if (reg_addr == `ADDR_STATE) begin
        rdata_q <= {10'h000, class_q, last_on_q, state_q};
      end else if (reg_addr == `ADDR_FAN_DUTY) begin
        rdata_q <= {8'h00, duty_q};
      end else if (reg_addr == `ADDR_FAN_RPM) begin
        rdata_q <= rpm_q;
      end else if (reg_addr == `ADDR_IRQ_STATUS) begin
        rdata_q <= {11'h000, irq_stat_q};
      end else if (reg_addr == `ADDR_IRQ_MASK) begin
        rdata_q <= {11'h000, mask_q};
      end else begin
        rdata_q <= 16'h0000; // Unmapped
      end
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // power_loss_and_fan_supervisor

`default_nettype wire

/* retain_store.v */
// Small retained store holding the restore policy and last on/off state.
// Contents are never reset, so they outlive a loss of the supervised rail.
// Read is write-first; read data comes out of a register.
`timescale 1ns/100ps
`default_nettype none

module retain_store (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       reset,
  // Write port
  input  wire       wr_en,
  input  wire [1:0] wr_idx,
  input  wire [7:0] wr_data,
  // Read port
  input  wire [1:0] rd_idx,
  output reg  [7:0] rd_data
);

  reg [7:0] mem [0:3];

  // Array write, kept out of reset on purpose
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Registered read, new data wins on a same-entry write
  always @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (wr_en && (wr_idx == rd_idx)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end

endmodule // retain_store

`default_nettype wire

/* supervisor_asserts.sv */
// Port-level checks of the power loss and fan supervisor.
// Assumes one clock domain and the constants header on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_consts.vh"
module supervisor_asserts #(
  parameter [30:0] WINDOW_CYCLES = 50,
  parameter [30:0] GATE_CYCLES   = 100
) (
  // Clock, reset, register port
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Supply, wake, fan, interrupt
  input wire logic        standby_present,
  input wire logic        standby_rail_fitted,
  input wire logic        supply_on_request_n,
  input wire logic        power_button_n,
  input wire logic        sleep_button_n,
  input wire logic        smbalert_n,
  input wire logic        fan_speed_drive,
  input wire logic        fan_rotation_pulse_in,
  input wire logic        irq
);
  reg [7:0] duty_q;
  // Tracks the duty last written over the port
  always @(posedge ref_clk)
    duty_q <= reset ? `DUTY_RESET
            : (reg_wr && reg_addr == `ADDR_FAN_DUTY) ? reg_wdata[7:0] : duty_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  a_unmapped_read: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_mask_clear_irq: assert property (reg_wr && reg_addr == `ADDR_IRQ_MASK && reg_wdata[4:0] == 5'h00 |=> !irq)
    else $error("irq with empty mask");
  a_standby_loss_off: assert property (!standby_present [*2] |=> supply_on_request_n)
    else $error("supply requested without standby");
  a_button_turns_off: assert property ($fell(power_button_n) && !supply_on_request_n
      && standby_present |=> supply_on_request_n)
    else $error("power button did not release supply");
  a_pwm_zero_low: assert property ((duty_q == 8'h00) [*3] |-> !fan_speed_drive)
    else $error("fan drive high at zero duty");
  a_state_code_range: assert property (reg_rd && reg_addr == `ADDR_STATE |=> reg_rdata[2:0] <= 3'h4)
    else $error("state code out of range");
  a_supply_tracks_state: assert property (reg_rd && reg_addr == `ADDR_STATE
      ##1 $stable(supply_on_request_n)
      |-> (reg_rdata[2:0] == 3'h1) == !$past(supply_on_request_n))
    else $error("supply request disagrees with state");
  c_supply_on: cover property (!supply_on_request_n);
  c_standby_back: cover property ($rose(standby_present));
  c_irq: cover property (irq);
endmodule // supervisor_asserts
bind power_loss_and_fan_supervisor supervisor_asserts #(.WINDOW_CYCLES(WINDOW_CYCLES),
  .GATE_CYCLES(GATE_CYCLES)) u_supervisor_asserts (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .standby_present(standby_present),
  .standby_rail_fitted(standby_rail_fitted), .supply_on_request_n(supply_on_request_n),
  .power_button_n(power_button_n), .sleep_button_n(sleep_button_n), .smbalert_n(smbalert_n),
  .fan_speed_drive(fan_speed_drive), .fan_rotation_pulse_in(fan_rotation_pulse_in), .irq(irq));
`default_nettype wire

/* supervisor_consts.vh */
// Constants for the power loss and fan supervisor: timing, register map,
// field positions and reset values.
// Assumes a 50 MHz reference clock and a 16-bit register port.
`ifndef SUPERVISOR_CONSTS_VH
`define SUPERVISOR_CONSTS_VH

// Clock and timing
`define CLK_HZ              50000000
`define WINDOW_SEC          30
`define TACH_GATE_SEC       1
`define SEC_PER_MIN         60
`define TACH_PULSES_PER_REV 2
// Window and gate lengths in clock cycles, sized for the 31-bit counters
`define WINDOW_CYCLES_DEF   31'd1500000000
`define GATE_CYCLES_DEF     31'd50000000

// Restore policies
`define POLICY_ON           2'h0
`define POLICY_OFF          2'h1
`define POLICY_LAST         2'h2

// Register byte addresses
`define ADDR_CONTROL        8'h00
`define ADDR_STATE          8'h04
`define ADDR_FAN_DUTY       8'h08
`define ADDR_FAN_RPM        8'h0C
`define ADDR_IRQ_STATUS     8'h10
`define ADDR_IRQ_MASK       8'h14

// Control register fields
`define CTL_POLICY_LSB      0
`define CTL_POLICY_MSB      1
`define CTL_ON_CMD          2
`define CTL_OFF_CMD         3
`define CTL_ESO_CMD         4

// Event and interrupt bits
`define IRQ_WIDTH           5
`define EV_POWER_ON         0
`define EV_POWER_OFF        1
`define EV_AC_LOSS          2
`define EV_ORDERLY          3
`define EV_WAKE             4

// Loss classification codes
`define CLASS_NONE          2'h0
`define CLASS_ORDERLY       2'h1
`define CLASS_AC_LOSS       2'h2

// Reset values
`define POLICY_RESET        2'h1
`define DUTY_RESET          8'h80
`define MASK_RESET          5'h00

// Retained store layout
`define STORE_IDX           2'h0
`define STORE_LAST_BIT      0
`define STORE_POL_LSB       1
`define STORE_POL_MSB       2

`endif

/* tb.sv */
// Self-checking bench for the power loss and fan supervisor.
// Assumes the supply and fan model on the far side; short window and gate.
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_consts.vh"
module tb;
  localparam [30:0] WIN = 50;
  localparam [30:0] GATE = 100;
  localparam int PULSE = 10;
  localparam [15:0] RPM = 16'((GATE / PULSE) * `SEC_PER_MIN / `TACH_PULSES_PER_REV);
  logic        ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, cut = 0, fitted = 1;
  logic        power_button_n = 1, sleep_button_n = 1, smbalert_n = 1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, d;
  wire  [15:0] reg_rdata;
  wire         standby_present, supply_on_request_n, fan_speed_drive, fan_rotation_pulse_in, irq;
  int          miscompares = 0, checks_done = 0, i, n;
  // Clock and hang guard
  always #10 ref_clk = ~ref_clk;
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end
  power_loss_and_fan_supervisor #(.WINDOW_CYCLES(WIN), .GATE_CYCLES(GATE))
    u_power_loss_and_fan_supervisor (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .standby_present(standby_present), .standby_rail_fitted(fitted),
    .supply_on_request_n(supply_on_request_n), .power_button_n(power_button_n),
    .sleep_button_n(sleep_button_n), .smbalert_n(smbalert_n), .fan_speed_drive(fan_speed_drive),
    .fan_rotation_pulse_in(fan_rotation_pulse_in), .irq(irq));
  atx_fan_model #(.PULSE_CYCLES(PULSE)) u_atx_fan_model (.ref_clk(ref_clk), .cut(cut),
    .supply_on_request_n(supply_on_request_n), .standby_present(standby_present),
    .fan_rotation_pulse_in(fan_rotation_pulse_in));
  // Compare and report
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle register write and read
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [15:0] m,
                    input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    if (m != 16'h0000) check(what, exp, d & m);
  endtask
  // Wake source press: 0 power, 1 sleep, 2 alert
  task automatic press(input int k);
    @(posedge ref_clk);
    power_button_n <= (k != 0);
    sleep_button_n <= (k != 1);
    smbalert_n <= (k != 2);
    @(posedge ref_clk);
    {power_button_n, sleep_button_n, smbalert_n} <= 3'h7;
    repeat (3) @(posedge ref_clk);
  endtask
  // Standby rail up or down, then settle
  task automatic rail(input logic up);
    @(posedge ref_clk);
    cut <= !up;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rc("state", `ADDR_STATE, 16'h003F, 16'h0000);
    rc("duty", `ADDR_FAN_DUTY, 16'hFFFF, {8'h00, `DUTY_RESET});
    rc("mask", `ADDR_IRQ_MASK, 16'hFFFF, 16'h0000);
    rc("unmapped", 8'h20, 16'hFFFF, 16'h0000);
    // Power button from off raises supply and an unmasked interrupt
    wr(`ADDR_IRQ_MASK, 16'h0001);
    press(0);
    for (n = 0; n < 20 && supply_on_request_n !== 1'b0; n++) @(posedge ref_clk);
    if (n == 20) begin
      miscompares++;
      conclude();
    end
    check("supply_n", 16'h0000, {15'h0, supply_on_request_n});
    check("irq", 16'h0001, {15'h0, irq});
    rc("status", `ADDR_IRQ_STATUS, 16'h0001, 16'h0001);
    check("irq_clr", 16'h0000, {15'h0, irq});
    wr(`ADDR_IRQ_MASK, 16'h0000);
    // Fan duty and tach readout
    wr(`ADDR_FAN_DUTY, 16'h0000);
    repeat (300) @(posedge ref_clk);
    wr(`ADDR_FAN_DUTY, 16'h0040);
    repeat (4) @(posedge ref_clk);
    n = 0;
    repeat (256) @(posedge ref_clk) n += (fan_speed_drive === 1'b1);
    check("pwm_high", 16'h0040, n[15:0]);
    rc("rpm", `ADDR_FAN_RPM, 16'hFFFF, RPM);
    // Last-state policy: full window gives orderly off, stays off on return
    wr(`ADDR_CONTROL, {14'h0, `POLICY_LAST});
    press(0);
    rc("watch", `ADDR_STATE, 16'h0007, 16'h0002);
    repeat (int'(WIN) + 10) @(posedge ref_clk);
    rc("orderly", `ADDR_STATE, 16'h003F, 16'h0010);
    rail(0);
    rail(1);
    rc("last_off", `ADDR_STATE, 16'h0007, 16'h0000);
    // Loss while on: AC loss, on again on return
    wr(`ADDR_CONTROL, 16'h0006);
    rail(0);
    rc("lost", `ADDR_STATE, 16'h003F, 16'h002C);
    check("irq_masked", 16'h0000, {15'h0, irq});
    rail(1);
    rc("last_on", `ADDR_STATE, 16'h0007, 16'h0001);
    // Loss inside the window: either recorded state accepted
    press(0);
    rail(0);
    rc("lost_win", `ADDR_STATE, 16'h0037, 16'h0024);
    rail(1);
    wr(`ADDR_CONTROL, 16'h0000);
    wr(`ADDR_CONTROL, 16'h0008);
    rc("no_window", `ADDR_STATE, 16'h0007, 16'h0000);
    // Power-on policy starts the system on return
    rail(0);
    rail(1);
    rc("pol_on", `ADDR_STATE, 16'h0007, 16'h0001);
    // Soft-off: on command refused, each wake source leaves
    for (i = 0; i < 3; i++) begin
      wr(`ADDR_CONTROL, 16'h0009);
      wr(`ADDR_CONTROL, 16'h0011);
      wr(`ADDR_CONTROL, 16'h0005);
      rc("soft_off", `ADDR_STATE, 16'h0007, 16'h0003);
      rc("", `ADDR_IRQ_STATUS, 16'h0000, 16'h0000);
      press(i);
      rc("wake", `ADDR_IRQ_STATUS, 16'h0010, 16'h0010);
      rc("", `ADDR_STATE, 16'h0000, 16'h0000);
      check("left", 16'h0000, {15'h0, d[2:0] == 3'h3});
    end
    // Stay-off policy keeps it down; without standby rail policy ignored
    rail(0);
    rail(1);
    rc("pol_off", `ADDR_STATE, 16'h0007, 16'h0000);
    @(posedge ref_clk);
    fitted <= 1'b0;
    rail(0);
    rail(1);
    rc("no_rail", `ADDR_STATE, 16'h0007, 16'h0001);
    conclude();
  end
endmodule // tb
`default_nettype wire
